// ==== shared/bio_pkg.sv ====
// Purpose: constants for the bidirectional I/O port block
// Assumes: 32-bit Avalon-MM register window, word addressed by index * 4
// Notes:   port indices follow the printed file addresses
package bio_pkg;
  // ==========================================================
  // register indices and byte addresses
  localparam logic [7:0] FIRST_PORT_IDX   = 8'h05;
  localparam logic [7:0] SECOND_PORT_IDX  = 8'h06;
  localparam logic [7:0] THIRD_PORT_IDX   = 8'h07;
  localparam logic [7:0] DIR_LOAD_IDX     = 8'h08;
  localparam logic [7:0] DIR_SEL_IDX      = 8'h09;
  localparam logic [7:0] BIT_OP_IDX       = 8'h0A;
  localparam logic [9:0] FIRST_PORT_ADDR  = {FIRST_PORT_IDX, 2'b00};
  localparam logic [9:0] SECOND_PORT_ADDR = {SECOND_PORT_IDX, 2'b00};
  localparam logic [9:0] THIRD_PORT_ADDR  = {THIRD_PORT_IDX, 2'b00};
  localparam logic [9:0] DIR_LOAD_ADDR    = {DIR_LOAD_IDX, 2'b00};
  localparam logic [9:0] DIR_SEL_ADDR     = {DIR_SEL_IDX, 2'b00};
  localparam logic [9:0] BIT_OP_ADDR      = {BIT_OP_IDX, 2'b00};
  // ==========================================================
  // fields and reset values
  localparam logic [7:0] DIR_RESET        = 8'hFF;
  localparam logic [7:0] FIRST_PORT_MASK  = 8'h0F;
  localparam int         BIT_OP_SET_POS   = 3;
  localparam int         BIT_OP_PORT_LSB  = 4;
  localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;
  // ==========================================================
  // bus answer state machine
  typedef enum logic [1:0] {
    BIO_IDLE   = 2'b00,
    BIO_SAMPLE = 2'b01,
    BIO_ANSWER = 2'b11
  } bio_state_type;
endpackage

// ==== rtl/bio_ports.sv ====
// Purpose: three bidirectional general purpose I/O ports behind Avalon-MM
// Assumes: pins synchronous to core_clk; one access at a time
// Notes:
// Contract
// - second port is eight bits, one data latch and one pin per bit.
// - third port is I/O when present, otherwise a plain storage register.
// - direction load copies the working value into the named direction register.
// - direction bit 1 releases the pin; 0 drives it from the data latch.
// - port reads return pin levels, not the data latches, except an absent third port, which reads its latch.
// - direction registers are unreadable and set to all ones on reset.
// - data latches keep their contents across reset; undefined at power-on.
// - first port has pins three to zero only; others read zero.
// - data latch holds its value until software writes it again.
// - every pin direction is set independently of its neighbours.
// - bit set or clear reads pins, changes one bit, writes that port's latches.
// - writes land at cycle end; reads sample pins at cycle start.
// - first port upper four bits are unimplemented and read zero.
`timescale 1ns/1ps
module bio_ports #(
  parameter bit HAS_THIRD_PORT = 1'b1
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  first_port_in,
  output logic [3:0]       first_port_out,
  output logic [3:0]       first_port_oe,
  input  wire logic [7:0]  second_port_in,
  output logic [7:0]       second_port_out,
  output logic [7:0]       second_port_oe,
  input  wire logic [7:0]  third_port_in,
  output logic [7:0]       third_port_out,
  output logic [7:0]       third_port_oe
);
  import bio_pkg::*;

  // ==========================================================
  // state
  bio_state_type state_reg;
  logic [3:0]    first_latch_reg;
  logic [7:0]    second_latch_reg;
  logic [7:0]    third_latch_reg;
  logic [3:0]    first_dir_reg;
  logic [7:0]    second_dir_reg;
  logic [7:0]    third_dir_reg;
  logic [1:0]    dir_sel_reg;
  logic [7:0]    pin_sample_reg;
  logic [31:0]   readdata_next;
  logic [7:0]    bit_op_next;
  logic          lane0;
  logic [2:0]    op_bit;
  logic [1:0]    op_port;
  logic          op_set;

  assign lane0   = avs_byteenable[0];
  assign op_bit  = avs_writedata[2:0];
  assign op_set  = avs_writedata[BIT_OP_SET_POS];
  assign op_port = avs_writedata[BIT_OP_PORT_LSB +: 2];

  // ==========================================================
  // bus sequencing: idle, sample pins at cycle start, answer at end
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      state_reg <= BIO_IDLE;
    else
      unique case (state_reg)
        BIO_IDLE:   if (avs_read || avs_write) state_reg <= BIO_SAMPLE;
        BIO_SAMPLE: state_reg <= BIO_ANSWER;
        BIO_ANSWER: state_reg <= BIO_IDLE;
      endcase
  end

  // pin levels taken at the start of the access cycle
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      pin_sample_reg <= 8'h00;
    else if (state_reg == BIO_IDLE && (avs_read || avs_write))
    begin
      unique case (avs_address)
        FIRST_PORT_ADDR:  pin_sample_reg <= {4'h0, first_port_in};
        SECOND_PORT_ADDR: pin_sample_reg <= second_port_in;
        THIRD_PORT_ADDR:  pin_sample_reg <= HAS_THIRD_PORT ? third_port_in
                                                           : third_latch_reg;
        BIT_OP_ADDR:
          unique case (avs_writedata[BIT_OP_PORT_LSB +: 2])
            2'd0:    pin_sample_reg <= {4'h0, first_port_in};
            2'd1:    pin_sample_reg <= second_port_in;
            default: pin_sample_reg <= HAS_THIRD_PORT ? third_port_in
                                                      : third_latch_reg;
          endcase
        default:   pin_sample_reg <= 8'h00;
      endcase
    end
  end

  // one bit changed in the sampled port value
  always_comb
  begin
    bit_op_next = pin_sample_reg;
    bit_op_next[op_bit] = op_set;
  end

  // answer and waitrequest registered so outputs come from flip-flops
  always_comb
  begin
    readdata_next = UNMAPPED_READ;
    unique case (avs_address)
      FIRST_PORT_ADDR, SECOND_PORT_ADDR, THIRD_PORT_ADDR:
        readdata_next = {24'h000000, pin_sample_reg};
      DIR_SEL_ADDR:
        readdata_next = {30'h0, dir_sel_reg};
      default:
        readdata_next = UNMAPPED_READ; // direction load reads zero
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      avs_readdata    <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      avs_waitrequest <= !(state_reg == BIO_SAMPLE);
      avs_readdata    <= (state_reg == BIO_SAMPLE && avs_read) ? readdata_next
                                                                : 32'h0000_0000;
    end
  end

  // write at end of access: the edge where waitrequest is seen low
  logic wr_fire;
  assign wr_fire = (state_reg == BIO_ANSWER) && avs_write && lane0;

  // ==========================================================
  // data latches: no reset term, kept across every reset
  always_ff @(posedge core_clk)
  begin
    if (wr_fire)
    begin
      unique case (avs_address)
        FIRST_PORT_ADDR:  first_latch_reg  <= avs_writedata[3:0];
        SECOND_PORT_ADDR: second_latch_reg <= avs_writedata[7:0];
        THIRD_PORT_ADDR:  third_latch_reg  <= avs_writedata[7:0];
        BIT_OP_ADDR:
          unique case (op_port)
            2'd0:    first_latch_reg  <= bit_op_next[3:0];
            2'd1:    second_latch_reg <= bit_op_next;
            2'd2:    third_latch_reg  <= bit_op_next;
            default: ;
          endcase
        default: ;
      endcase
    end
  end

  // port selector for the direction load
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      dir_sel_reg <= 2'd1;
    else if (wr_fire && avs_address == DIR_SEL_ADDR)
      dir_sel_reg <= avs_writedata[1:0];
  end

  // direction registers, all ones on reset, write-only
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      first_dir_reg  <= DIR_RESET[3:0];
      second_dir_reg <= DIR_RESET;
      third_dir_reg  <= DIR_RESET;
    end
    else if (wr_fire && avs_address == DIR_LOAD_ADDR)
    begin
      unique case (dir_sel_reg)
        2'd0: first_dir_reg  <= avs_writedata[3:0];
        2'd1: second_dir_reg <= avs_writedata[7:0];
        2'd2: if (HAS_THIRD_PORT) third_dir_reg <= avs_writedata[7:0];
        default: ; // no such port
      endcase
    end
  end

  // ==========================================================
  // pin drivers: enable high while driving, direction 0 drives
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      first_port_oe  <= 4'h0;
      second_port_oe <= 8'h00;
      third_port_oe  <= 8'h00;
      first_port_out  <= 4'h0;
      second_port_out <= 8'h00;
      third_port_out  <= 8'h00;
    end
    else
    begin
      first_port_oe   <= ~first_dir_reg;
      second_port_oe  <= ~second_dir_reg;
      third_port_oe   <= HAS_THIRD_PORT ? ~third_dir_reg : 8'h00;
      first_port_out  <= first_latch_reg;
      second_port_out <= second_latch_reg;
      third_port_out  <= HAS_THIRD_PORT ? third_latch_reg : 8'h00;
    end
  end

  // ==========================================================
  // checks
  bus_answer_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == BIO_IDLE && (avs_read || avs_write)) |=> ##1 !avs_waitrequest)
    else $error("answer not two cycles after request");
  dir_reset_a: assert property (@(posedge core_clk)
    !nrst |=> (second_dir_reg == DIR_RESET && first_dir_reg == 4'hF))
    else $error("direction not all ones after reset");
  drive_follow_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ##1 (second_port_oe == ~$past(second_dir_reg)))
    else $error("output enable does not follow direction");
  latch_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !wr_fire |=> $stable(second_latch_reg))
    else $error("latch changed without write");
  pin_read_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == BIO_IDLE && avs_read && avs_address == SECOND_PORT_ADDR)
    ##2 avs_read |-> avs_readdata[7:0] == $past(second_port_in, 2))
    else $error("read does not return sampled pins");
  upper_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == BIO_SAMPLE && avs_address == FIRST_PORT_ADDR) |=>
    avs_readdata[31:4] == 28'h0)
    else $error("first port upper bits not zero");
  bit_op_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_fire && avs_address == BIT_OP_ADDR && op_port == 2'd1) |=>
    second_latch_reg[$past(op_bit)] == $past(op_set))
    else $error("bit operation wrong");
  absent_port_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_fire && avs_address == DIR_LOAD_ADDR && dir_sel_reg == 2'd3) |=>
    $stable(first_dir_reg) && $stable(second_dir_reg) && $stable(third_dir_reg))
    else $error("absent port direction load changed state");
  dir_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_fire && avs_address == DIR_LOAD_ADDR && dir_sel_reg == 2'd1) |=>
    second_dir_reg == $past(avs_writedata[7:0]))
    else $error("direction load did not copy value");

  // ==========================================================
  // further checks on drivers, bus answer, direction registers and latches

  // first port enables track its direction bits
  first_oe_follow_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ##1 (first_port_oe == ~$past(first_dir_reg)))
    else $error("first port enable does not follow direction");

  // third port enables track direction, or stay off when absent
  third_oe_follow_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ##1 (third_port_oe == (HAS_THIRD_PORT ? ~$past(third_dir_reg) : 8'h00)))
    else $error("third port enable does not follow direction");

  // no answer while the sequencer is idle
  wait_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == BIO_IDLE) |-> avs_waitrequest)
    else $error("waitrequest low while idle");

  // waitrequest low for exactly one cycle
  wait_once_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  // read data zero outside the answer cycle
  read_quiet_a: assert property (@(posedge core_clk) disable iff (!nrst)
    avs_waitrequest |-> avs_readdata == 32'h0000_0000)
    else $error("read data not zero outside answer");

  // a request in idle moves on to the sampling step
  seq_sample_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == BIO_IDLE && (avs_read || avs_write)) |=> state_reg == BIO_SAMPLE)
    else $error("request did not start sampling");

  // answer step always returns to idle
  seq_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == BIO_ANSWER) |=> state_reg == BIO_IDLE)
    else $error("answer did not return to idle");

  // direction load address never reveals a direction value
  dir_unread_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == BIO_ANSWER && avs_read && avs_address == DIR_LOAD_ADDR) |->
    avs_readdata == 32'h0000_0000)
    else $error("direction register readable");

  // first port upper bits read as zero in the answer
  first_upper_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == BIO_ANSWER && avs_read && avs_address == FIRST_PORT_ADDR) |->
    avs_readdata[31:4] == 28'h0)
    else $error("first port upper bits not zero in answer");

  // first port read returns pins from the request edge
  first_read_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == BIO_IDLE && avs_read && avs_address == FIRST_PORT_ADDR)
    ##2 avs_read |-> avs_readdata[3:0] == $past(first_port_in, 2))
    else $error("first port read does not return pins");

  // third port read returns pins, or the latch when absent
  third_read_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == BIO_IDLE && avs_read && avs_address == THIRD_PORT_ADDR)
    ##2 avs_read |-> avs_readdata[7:0] ==
    $past(HAS_THIRD_PORT ? third_port_in : third_latch_reg, 2))
    else $error("third port read wrong");

  // port selector comes out of reset on the second port
  dir_sel_reset_a: assert property (@(posedge core_clk)
    !nrst |=> dir_sel_reg == 2'd1)
    else $error("port selector wrong after reset");

  // first port load leaves the other directions alone
  first_dir_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_fire && avs_address == DIR_LOAD_ADDR && dir_sel_reg == 2'd0) |=>
    first_dir_reg == $past(avs_writedata[3:0]) && $stable(second_dir_reg)
    && $stable(third_dir_reg))
    else $error("first port direction load wrong");

  // third port load only when the port exists
  third_dir_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_fire && avs_address == DIR_LOAD_ADDR && dir_sel_reg == 2'd2) |=>
    third_dir_reg == (HAS_THIRD_PORT ? $past(avs_writedata[7:0]) : $past(third_dir_reg)))
    else $error("third port direction load wrong");

  // reads never disturb a data latch
  read_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == BIO_ANSWER && avs_read) |=>
    $stable(first_latch_reg) && $stable(second_latch_reg) && $stable(third_latch_reg))
    else $error("read changed a data latch");

  // writes without byte lane zero are refused
  lane_refuse_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == BIO_ANSWER && avs_write && !lane0) |=>
    $stable(first_latch_reg) && $stable(second_latch_reg) && $stable(third_latch_reg))
    else $error("write without lane zero changed a latch");

  // bit operation on the first port gives the named bit the set or clear value
  first_bit_op_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_fire && avs_address == BIT_OP_ADDR && op_port == 2'd0) |=>
    first_latch_reg[$past(op_bit[1:0])] == $past(op_set))
    else $error("first port bit operation wrong");

  // bit operation on the third port gives the named bit the set or clear value
  third_bit_op_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_fire && avs_address == BIT_OP_ADDR && op_port == 2'd2) |=>
    third_latch_reg[$past(op_bit)] == $past(op_set))
    else $error("third port bit operation wrong");

endmodule

// ==== tb/bio_pins.sv ====
// Purpose: outside circuitry on one port's pins
// Assumes: outside drive overrides the device driver on a pin
// Notes:   a pin nobody drives shows the inverse of its last level
`timescale 1ns/1ps
module bio_pins #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic [W-1:0] drv_out,
  input  wire logic [W-1:0] drv_oe,
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  output logic [W-1:0]      pin
);
  logic [W-1:0] float_reg;
  // floating level flips every cycle, from a known start
  initial float_reg = '0;
  always @(posedge core_clk)
    float_reg <= ~pin;
  // pin shows outside drive if enabled, else the device driver if enabled, else the floating level
  assign pin = (ext_en & ext_val) | (~ext_en & drv_oe & drv_out)
             | (~ext_en & ~drv_oe & float_reg);
endmodule

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the I/O port block
// Assumes: Avalon-MM master, one access at a time
// Notes:   model arrays track latches, directions and outside drive
`timescale 1ns/1ps
module testbench;
  import bio_pkg::*;
  logic        core_clk = 0, nrst = 0, avs_read = 0, avs_write = 0;
  logic [9:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  logic [3:0]  avs_byteenable = 0, pa, ao, ae;
  logic [7:0]  pb, pc, bo, be, co, ce, v;
  logic [7:0]  lat [3], dir [3], een [3], evl [3], dout [3], doe [3];
  logic        avs_waitrequest;
  int          bad_count = 0, check_count = 0, b;
  always #10 core_clk = ~core_clk;
  assign dout = '{{4'h0, ao}, bo, co};
  assign doe = '{{4'h0, ae}, be, ce};
  bio_ports i_dut (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .first_port_in(pa), .first_port_out(ao),
    .first_port_oe(ae), .second_port_in(pb), .second_port_out(bo),
    .second_port_oe(be), .third_port_in(pc), .third_port_out(co), .third_port_oe(ce));
  bio_pins #(.W(4)) i_pa (.core_clk(core_clk), .drv_out(ao), .drv_oe(ae),
    .ext_val(evl[0][3:0]), .ext_en(een[0][3:0]), .pin(pa));
  bio_pins #(.W(8)) i_pb (.core_clk(core_clk), .drv_out(bo), .drv_oe(be),
    .ext_val(evl[1]), .ext_en(een[1]), .pin(pb));
  bio_pins #(.W(8)) i_pc (.core_clk(core_clk), .drv_out(co), .drv_oe(ce),
    .ext_val(evl[2]), .ext_en(een[2]), .pin(pc));
  // ==========================================================
  // helpers
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // one Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] en, output logic [31:0] r);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= en;
    avs_write <= wr;
    avs_read <= !wr;
    // only the watchdog ends a wait that never sees waitrequest low
    do
    begin
      @(posedge core_clk);
    end
    while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic [7:0] msk(int p);
    return (p == 0) ? FIRST_PORT_MASK : 8'hFF;
  endfunction
  function automatic logic [9:0] padr(int p);
    return FIRST_PORT_ADDR + 10'(4 * p);
  endfunction
  // level each pin should show: outside drive, else own latch
  function automatic logic [7:0] pins(int p);
    return ((een[p] & evl[p]) | (~een[p] & lat[p])) & msk(p);
  endfunction
  task automatic set_dir(int p, logic [7:0] d);
    bus(1, DIR_SEL_ADDR, 32'(p), 4'hF, q);
    bus(1, DIR_LOAD_ADDR, {24'h0, d}, 4'hF, q);
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    report_and_stop();
  end
  // ==========================================================
  // tests
  initial
  begin
    for (int p = 0; p < 3; p++)
    begin
      een[p] = 8'h00;
      evl[p] = 8'h00;
    end
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    void'($urandom(32'h7738));
    for (int p = 0; p < 3; p++)
      chk("oe after reset", 0, doe[p]);
    bus(0, DIR_SEL_ADDR, 0, 4'h0, q);
    chk("port select", 1, q);
    bus(0, DIR_LOAD_ADDR, 0, 4'h0, q);
    chk("direction read", 0, q);
    bus(0, 10'h3FC, 0, 4'h0, q);
    chk("unmapped read", 0, q);
    $display("test reset done");
    for (int p = 0; p < 3; p++)
    begin
      dir[p] = 8'($urandom);
      lat[p] = 8'($urandom);
      evl[p] = 8'($urandom);
      een[p] = dir[p] | (8'h01 << $urandom_range(7));
      set_dir(p, dir[p]);
      bus(1, padr(p), {24'h0, lat[p]}, 4'hF, q);
      repeat (3) @(posedge core_clk); // settle before reading the same port
      chk("oe", ~dir[p] & msk(p), doe[p]);
      chk("out", lat[p] & msk(p), dout[p]);
      bus(0, padr(p), 0, 4'hF, q);
      chk("pin read", pins(p), q);
      b = $urandom_range(p == 0 ? 3 : 7);
      v = 8'($urandom_range(1));
      bus(1, BIT_OP_ADDR, 32'(b) | (32'(v) << 3) | (32'(p) << 4), 4'hF, q);
      lat[p] = pins(p);
      lat[p][b] = v[0];
      bus(1, padr(p), ~lat[p], 4'h0, q);
      repeat (3) @(posedge core_clk);
      chk("bit op", lat[p] & msk(p), dout[p]);
      een[p] = 8'hFF;
      set_dir(p, 8'hFF);
      repeat (3) @(posedge core_clk);
      chk("latch hold", lat[p] & msk(p), dout[p]);
      set_dir(p, 8'h00);
      een[p] = 8'h00;
      $display("test port %0d done", p);
    end
    set_dir(3, 8'hFF);
    repeat (3) @(posedge core_clk);
    for (int p = 0; p < 3; p++)
      chk("absent port", msk(p), doe[p]);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int p = 0; p < 3; p++)
    begin
      chk("oe reset", 0, doe[p]);
      chk("latch kept", lat[p] & msk(p), dout[p]);
    end
    $display("test second reset done");
    report_and_stop();
  end
endmodule
